// ### hdl/umc_mode_config.sv
`timescale 1ns/1ps
`include "umc_defs.svh"
// ----------------------------------------
// ----------------------------------------
module umc_mode_config (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic i_cnd,
	input wire logic [7:0] i_din,
	input wire logic i_rxc_n,
	input wire logic i_txc_n,
	input wire logic i_rxd,
	input wire logic i_ext_sync,
	input wire logic i_sync_match,
	input wire logic i_sync_miss,
	input wire logic i_hunt,
	input wire logic i_tx_en,
	input wire logic i_int_reset,
	output logic [7:0] o_mode_word,
	output logic o_mode_loaded,
	output logic o_mode_bad,
	output logic o_sync_mode,
	output umc_pkg::umc_rate_t o_rate,
	output logic [3:0] o_char_len,
	output logic o_parity_en,
	output logic o_parity_even,
	output logic [1:0] o_stop_code,
	output logic o_ext_sync_sel,
	output logic o_single_sync,
	output logic o_sync_locked,
	output logic o_cmd_wr,
	output logic [7:0] o_cmd_data,
	output logic o_tx_wr,
	output logic o_rx_sample,
	output logic o_rx_bit,
	output logic o_rx_frame_end,
	output logic o_rx_false_start,
	output logic o_tx_shift,
	output logic o_tx_done,
	output logic o_tx_busy
);
	// ----------------------------------------
	// host write strobes and serial clock edges
	// ----------------------------------------
	logic wr_prev;
	logic rxc_prev;
	logic txc_prev;
	logic wr_act;
	logic wr_start;
	logic ctl_wr;
	logic data_wr;
	logic rxc_rise;
	logic txc_fall;

	// one strobe per write, taken on its first cycle
	assign wr_act = !i_cs_n && !i_wr_n;
	assign wr_start = wr_act && !wr_prev;
	assign ctl_wr = wr_start && i_cnd;
	assign data_wr = wr_start && !i_cnd;
	assign rxc_rise = i_rxc_n && !rxc_prev;
	assign txc_fall = !i_txc_n && txc_prev;

	// previous levels for edge detection
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_prev <= 1'b0;
			rxc_prev <= 1'b1;
			txc_prev <= 1'b1;
		end else begin
			wr_prev <= wr_act;
			rxc_prev <= i_rxc_n;
			txc_prev <= i_txc_n;
		end
	end

	// ----------------------------------------
	// mode word capture and control routing
	// ----------------------------------------
	// first control write after reset is the mode word
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_mode_word <= `UMC_MODE_RESET;
			o_mode_loaded <= 1'b0;
			o_cmd_wr <= 1'b0;
			o_cmd_data <= 8'h00;
		end else begin
			o_cmd_wr <= 1'b0;
			if (i_int_reset) begin
				o_mode_loaded <= 1'b0;
			end else if (ctl_wr) begin
				if (!o_mode_loaded) begin
					o_mode_word <= i_din;
					o_mode_loaded <= 1'b1;
				end else begin
					o_cmd_wr <= 1'b1;
					o_cmd_data <= i_din;
				end
			end
		end
	end

	// transmit data write strobe
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_tx_wr <= 1'b0;
		else
			o_tx_wr <= data_wr;
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	logic next_sync;
	logic [7:0] next_div;
	logic [7:0] next_stop_ticks;
	logic [3:0] next_rx_bits;
	logic [3:0] next_tx_bits;
	logic [3:0] len;
	logic [7:0] div;
	logic [7:0] stop_ticks;
	logic [3:0] rx_bits;
	logic [3:0] tx_bits;
	logic par;

	assign len = `UMC_LEN_BASE + {2'b00, o_mode_word[`UMC_LEN_LSB +: 2]};
	assign par = o_mode_word[`UMC_PEN_BIT];

	// frame sizes and timing from the mode word
	always_comb begin
		next_sync = o_mode_word[1:0] == 2'b00;
		case (o_mode_word[1:0])
			2'b10: next_div = `UMC_DIV16;
			2'b11: next_div = `UMC_DIV64;
			default: next_div = `UMC_DIV1;
		endcase
		case (o_mode_word[`UMC_STOP_LSB +: 2])
			2'b10: next_stop_ticks = next_div + {1'b0, next_div[7:1]};
			2'b11: next_stop_ticks = {next_div[6:0], 1'b0};
			default: next_stop_ticks = next_div;
		endcase
		if (next_sync) begin
			next_stop_ticks = next_div;
			next_rx_bits = len + {3'h0, par};
			next_tx_bits = len + {3'h0, par};
		end else begin
			next_rx_bits = len + {3'h0, par} + 4'h2;
			next_tx_bits = len + {3'h0, par} + 4'h2;
		end
	end

	// registered field decode
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_sync_mode <= 1'b1;
			o_rate <= umc_pkg::rate_sync;
			o_char_len <= `UMC_LEN_BASE;
			o_parity_en <= 1'b0;
			o_parity_even <= 1'b0;
			o_stop_code <= 2'b00;
			o_ext_sync_sel <= 1'b0;
			o_single_sync <= 1'b0;
			o_mode_bad <= 1'b0;
			div <= `UMC_DIV1;
			stop_ticks <= `UMC_DIV1;
			rx_bits <= 4'h0;
			tx_bits <= 4'h0;
		end else begin
			o_sync_mode <= next_sync;
			o_rate <= umc_pkg::umc_rate_t'(o_mode_word[1:0]);
			o_char_len <= len;
			o_parity_en <= par;
			o_parity_even <= par && o_mode_word[`UMC_EVEN_BIT];
			o_stop_code <= next_sync ? 2'b00 : o_mode_word[`UMC_STOP_LSB +: 2];
			o_ext_sync_sel <= next_sync && o_mode_word[`UMC_ESD_BIT];
			o_single_sync <= next_sync && o_mode_word[`UMC_SCS_BIT];
			o_mode_bad <= o_mode_loaded && !next_sync
				&& o_mode_word[`UMC_STOP_LSB +: 2] == 2'b00;
			div <= next_div;
			stop_ticks <= next_stop_ticks;
			rx_bits <= next_rx_bits;
			tx_bits <= next_tx_bits;
		end
	end

	// ----------------------------------------
	// sync acquisition
	// ----------------------------------------
	umc_pkg::umc_hunt_t hunt;
	logic rx_run;

	// character count to lock, or external indication
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			hunt <= umc_pkg::hunt_none;
		end else if (!o_sync_mode || i_hunt) begin
			hunt <= umc_pkg::hunt_none;
		end else if (o_ext_sync_sel) begin
			if (i_ext_sync)
				hunt <= umc_pkg::hunt_lock;
		end else begin
			case (hunt)
				umc_pkg::hunt_none: begin
					if (i_sync_match)
						hunt <= o_single_sync ? umc_pkg::hunt_lock : umc_pkg::hunt_one;
				end
				umc_pkg::hunt_one: begin
					if (i_sync_match)
						hunt <= umc_pkg::hunt_lock;
					else if (i_sync_miss)
						hunt <= umc_pkg::hunt_none;
				end
				umc_pkg::hunt_lock: hunt <= umc_pkg::hunt_lock;
				default: hunt <= umc_pkg::hunt_none;
			endcase
		end
	end

	// lock flag for the host side
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_sync_locked <= 1'b0;
		else
			o_sync_locked <= hunt == umc_pkg::hunt_lock;
	end

	// external sync gates reception, internal hunt needs every bit
	assign rx_run = !o_ext_sync_sel || hunt == umc_pkg::hunt_lock;

	// ----------------------------------------
	// receive and transmit timing, one shared rate
	// ----------------------------------------
	umc_rx_timing u_rx (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_rise(rxc_rise),
		.i_rxd(i_rxd),
		.i_rate(o_rate),
		.i_sync_run(rx_run),
		.i_bits(rx_bits),
		.o_sample(o_rx_sample),
		.o_bit(o_rx_bit),
		.o_frame_end(o_rx_frame_end),
		.o_false_start(o_rx_false_start)
	);

	umc_tx_timing u_tx (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_fall(txc_fall),
		.i_load(data_wr),
		.i_enable(i_tx_en),
		.i_div(div),
		.i_bits(tx_bits),
		.i_stop_ticks(stop_ticks),
		.o_shift(o_tx_shift),
		.o_done(o_tx_done),
		.o_busy(o_tx_busy)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sync_select_a: assert property (
		ctl_wr && !o_mode_loaded && !i_int_reset
		|-> ##2 o_sync_mode == (($past(i_din, 2) & 8'h03) == 8'h00))
		else $error("sync select does not follow mode bits");
	first_mode_a: assert property (
		ctl_wr && !o_mode_loaded && !i_int_reset
		|=> o_mode_loaded && o_mode_word == $past(i_din) && !o_cmd_wr)
		else $error("first control write not taken as mode");
	later_ctl_a: assert property (
		ctl_wr && o_mode_loaded && !i_int_reset
		|=> o_cmd_wr && $stable(o_mode_word) && o_cmd_data == $past(i_din))
		else $error("later control write altered the mode");
	char_len_a: assert property (
		$stable(o_mode_word) |-> o_char_len == 4'h5 + {2'b00, o_mode_word[3:2]})
		else $error("character length decode wrong");
	parity_sel_a: assert property (
		$stable(o_mode_word) |-> o_parity_en == o_mode_word[4]
			&& o_parity_even == (o_mode_word[4] && o_mode_word[5]))
		else $error("parity decode wrong");
	stop_code_a: assert property (
		$stable(o_mode_word) && o_mode_word[1:0] != 2'b00
		|-> o_stop_code == o_mode_word[7:6] && !o_ext_sync_sel && !o_single_sync)
		else $error("stop code decode wrong");
	single_lock_a: assert property (
		o_sync_mode && !o_ext_sync_sel && o_single_sync && !i_hunt
		&& hunt == umc_pkg::hunt_none && i_sync_match |=> ##1 o_sync_locked)
		else $error("single sync character did not lock");
	double_lock_a: assert property (
		o_sync_mode && !o_ext_sync_sel && !o_single_sync && !i_hunt
		&& hunt == umc_pkg::hunt_none && i_sync_match |=> !o_sync_locked[*2])
		else $error("locked on one of two sync characters");
	ext_lock_a: assert property (
		o_sync_mode && o_ext_sync_sel && i_ext_sync && !i_hunt |=> ##1 o_sync_locked)
		else $error("external sync did not start reception");
	mode_load_c: cover property (ctl_wr && !o_mode_loaded);
	cmd_route_c: cover property (o_cmd_wr);
	sync_lock_c: cover property (o_sync_locked && !o_ext_sync_sel);
endmodule : umc_mode_config

// ### hdl/umc_defs.svh
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH
// ----------------------------------------
// mode word reset value and field positions
// ----------------------------------------
`define UMC_MODE_RESET 8'h00
`define UMC_LEN_LSB 2
`define UMC_PEN_BIT 4
`define UMC_EVEN_BIT 5
`define UMC_STOP_LSB 6
`define UMC_ESD_BIT 6
`define UMC_SCS_BIT 7
`define UMC_LEN_BASE 4'h5
// ----------------------------------------
// clock-to-bit-rate timing counts
// ----------------------------------------
`define UMC_DIV1 8'h01
`define UMC_DIV16 8'h10
`define UMC_DIV64 8'h40
`define UMC_FIRST16 8'h08
`define UMC_FIRST64 8'h20
`define UMC_EDGE16 8'h09
`define UMC_EDGE64 8'h21
`endif

// ### hdl/umc_pkg.sv
package umc_pkg;
	typedef enum logic [1:0] {
		rate_sync = 2'h0,
		rate_x1 = 2'h1,
		rate_x16 = 2'h2,
		rate_x64 = 2'h3
	} umc_rate_t;
	typedef enum logic [1:0] {
		rx_idle = 2'h1,
		rx_run = 2'h2
	} umc_rx_state_t;
	typedef enum logic [2:0] {
		tx_idle = 3'h1,
		tx_wait = 3'h2,
		tx_run = 3'h4
	} umc_tx_state_t;
	typedef enum logic [2:0] {
		hunt_none = 3'h1,
		hunt_one = 3'h2,
		hunt_lock = 3'h4
	} umc_hunt_t;
endpackage : umc_pkg

// ### hdl/umc_rx_timing.sv
`timescale 1ns/1ps
`include "umc_defs.svh"
module umc_rx_timing (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_rise,
	input wire logic i_rxd,
	input wire umc_pkg::umc_rate_t i_rate,
	input wire logic i_sync_run,
	input wire logic [3:0] i_bits,
	output logic o_sample,
	output logic o_bit,
	output logic o_frame_end,
	output logic o_false_start
);
	umc_pkg::umc_rx_state_t state;
	logic [7:0] cnt;
	logic [3:0] left;
	logic [7:0] div;
	logic [7:0] rise_cnt;
	logic first_done;

	// bit period for the shared rate
	always_comb begin
		case (i_rate)
			umc_pkg::rate_x16: div = `UMC_DIV16;
			umc_pkg::rate_x64: div = `UMC_DIV64;
			default: div = `UMC_DIV1;
		endcase
	end

	// start detection and bit-centre sampling
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= umc_pkg::rx_idle;
			cnt <= 8'h00;
			left <= 4'h0;
			o_sample <= 1'b0;
			o_bit <= 1'b1;
			o_frame_end <= 1'b0;
			o_false_start <= 1'b0;
		end else begin
			o_sample <= 1'b0;
			o_frame_end <= 1'b0;
			o_false_start <= 1'b0;
			if (i_rate == umc_pkg::rate_sync) begin
				state <= umc_pkg::rx_idle;
				if (i_rise && i_sync_run) begin
					o_sample <= 1'b1;
					o_bit <= i_rxd;
				end
			end else begin
				case (state)
					umc_pkg::rx_idle: begin
						if (i_rise && !i_rxd) begin
							state <= umc_pkg::rx_run;
							left <= i_bits;
							if (i_rate == umc_pkg::rate_x1) begin
								o_sample <= 1'b1;
								o_bit <= 1'b0;
								left <= i_bits - 4'h1;
								cnt <= `UMC_DIV1;
							end else if (i_rate == umc_pkg::rate_x16) begin
								cnt <= `UMC_FIRST16;
							end else begin
								cnt <= `UMC_FIRST64;
							end
						end
					end
					umc_pkg::rx_run: begin
						if (i_rise) begin
							if (cnt == 8'h01) begin
								o_sample <= 1'b1;
								o_bit <= i_rxd;
								cnt <= div;
								left <= left - 4'h1;
								if (left == i_bits && i_rxd) begin
									o_false_start <= 1'b1;
									state <= umc_pkg::rx_idle;
								end else if (left == 4'h1) begin
									o_frame_end <= 1'b1;
									state <= umc_pkg::rx_idle;
								end
							end else begin
								cnt <= cnt - 8'h01;
							end
						end
					end
					default: state <= umc_pkg::rx_idle;
				endcase
			end
		end
	end

	// edge count since start detection, for checking only
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rise_cnt <= 8'h00;
			first_done <= 1'b1;
		end else if (state == umc_pkg::rx_idle && i_rise && !i_rxd) begin
			rise_cnt <= 8'h01;
			first_done <= 1'b0;
		end else begin
			if (i_rise && rise_cnt != 8'hFF)
				rise_cnt <= rise_cnt + 8'h01;
			if (o_sample)
				first_done <= 1'b1;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	x16_centre_a: assert property (
		o_sample && !first_done && i_rate == umc_pkg::rate_x16 |-> rise_cnt == `UMC_EDGE16)
		else $error("x16 first sample not on ninth edge");
	x64_centre_a: assert property (
		o_sample && !first_done && i_rate == umc_pkg::rate_x64 |-> rise_cnt == `UMC_EDGE64)
		else $error("x64 first sample not on 33rd edge");
	x1_every_edge_a: assert property (
		state == umc_pkg::rx_run && i_rate == umc_pkg::rate_x1 && i_rise |=> o_sample)
		else $error("x1 receive edge without sample");
	frame_end_c: cover property (o_frame_end);
endmodule : umc_rx_timing

// ### hdl/umc_tx_timing.sv
`timescale 1ns/1ps
module umc_tx_timing (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_fall,
	input wire logic i_load,
	input wire logic i_enable,
	input wire logic [7:0] i_div,
	input wire logic [3:0] i_bits,
	input wire logic [7:0] i_stop_ticks,
	output logic o_shift,
	output logic o_done,
	output logic o_busy
);
	umc_pkg::umc_tx_state_t state;
	logic [7:0] cnt;
	logic [3:0] left;
	logic [7:0] fall_cnt;
	logic [7:0] gap_len;
	logic gap_valid;

	// transmit bit pacing on falling clock edges
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state <= umc_pkg::tx_idle;
			cnt <= 8'h00;
			left <= 4'h0;
			o_shift <= 1'b0;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_shift <= 1'b0;
			o_done <= 1'b0;
			case (state)
				umc_pkg::tx_idle: begin
					if (i_load) begin
						state <= umc_pkg::tx_wait;
						o_busy <= 1'b1;
					end
				end
				umc_pkg::tx_wait: begin
					if (i_fall && i_enable) begin
						o_shift <= 1'b1;
						cnt <= (i_bits == 4'h1) ? i_stop_ticks : i_div;
						left <= i_bits - 4'h1;
						state <= umc_pkg::tx_run;
					end
				end
				umc_pkg::tx_run: begin
					if (i_fall) begin
						if (cnt != 8'h01) begin
							cnt <= cnt - 8'h01;
						end else if (left == 4'h0) begin
							o_done <= 1'b1;
							o_busy <= 1'b0;
							state <= umc_pkg::tx_idle;
						end else begin
							o_shift <= 1'b1;
							left <= left - 4'h1;
							cnt <= (left == 4'h1) ? i_stop_ticks : i_div;
						end
					end
				end
				default: state <= umc_pkg::tx_idle;
			endcase
		end
	end

	// falling edges between shifts, for checking only
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			fall_cnt <= 8'h00;
			gap_len <= 8'h00;
			gap_valid <= 1'b0;
		end else begin
			if (i_fall && fall_cnt != 8'hFF)
				fall_cnt <= fall_cnt + 8'h01;
			if (i_fall && state == umc_pkg::tx_wait && i_enable) begin
				fall_cnt <= 8'h00;
				gap_valid <= 1'b0;
			end else if (i_fall && state == umc_pkg::tx_run && cnt == 8'h01) begin
				fall_cnt <= 8'h00;
				gap_len <= fall_cnt + 8'h01;
				gap_valid <= left != 4'h0;
			end
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	tx_first_edge_a: assert property (
		state == umc_pkg::tx_wait && i_fall && i_enable |=> o_shift)
		else $error("first shift missed the next falling edge");
	tx_period_a: assert property (
		o_shift && gap_valid |-> gap_len == i_div)
		else $error("bit period differs from rate factor");
	tx_hold_a: assert property (
		state == umc_pkg::tx_wait && !i_enable |=> !o_shift)
		else $error("shift while transmission disabled");
	tx_done_c: cover property (o_done);
endmodule : umc_tx_timing

// ### testbench/umc_serial_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side serial peer: receive/transmit clocks and receive data
// ----------------------------------------
module umc_serial_peer (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_rxd_lvl,
	output logic o_rxc_n,
	output logic o_txc_n,
	output logic o_rxd
);
	logic [1:0] ph;
	// serial clock, four master cycles a period, stands still when not running
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ph <= 2'h0;
			o_rxc_n <= 1'b1;
		end else if (i_run) begin
			ph <= ph + 2'h1;
			if (ph[0])
				o_rxc_n <= ~o_rxc_n;
		end
	end
	// one clock paces both directions
	assign o_txc_n = o_rxc_n;
	// data changes only as the clock falls, so it is settled at the rise
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_rxd <= 1'b1;
		else if (!i_run)
			o_rxd <= 1'b1; // idle mark between frames
		else if (ph[0] && o_rxc_n)
			o_rxd <= i_rxd_lvl;
	end
endmodule : umc_serial_peer

// ### testbench/umc_mode_config_tb.sv
`timescale 1ns/1ps
module umc_mode_config_tb;
	logic i_mclk, i_rst, i_cs_n, i_wr_n, i_cnd, i_rxc_n, i_txc_n, i_rxd, run, rxd_lvl, s;
	logic i_ext_sync, i_sync_match, i_sync_miss, i_hunt, i_tx_en, i_int_reset, rxc_q, txc_q;
	logic [7:0] i_din, o_mode_word, o_cmd_data, m, e, g;
	logic o_mode_loaded, o_mode_bad, o_sync_mode, o_parity_en, o_parity_even, o_ext_sync_sel;
	logic o_single_sync, o_sync_locked, o_cmd_wr, o_tx_wr, o_rx_sample, o_rx_bit;
	logic o_rx_frame_end, o_rx_false_start, o_tx_shift, o_tx_done, o_tx_busy;
	logic [3:0] o_char_len;
	logic [1:0] o_stop_code;
	umc_pkg::umc_rate_t o_rate;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	int rise_n, fall_n, samp_at, sh_n, cmd_n, n;
	int done_at, fe_at, fs_at, twr_n;
	int sh_at [2];
	logic [7:0] divs [1:3] = '{8'h01, 8'h10, 8'h40};
	logic [7:0] firsts [1:3] = '{8'h01, 8'h09, 8'h21};
	// stop time in transmit clocks: one stop x1, one and a half x16, two x64
	logic [7:0] stops [1:3] = '{8'h01, 8'h18, 8'h80};

	umc_mode_config i_umc_mode_config (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n), .i_cnd(i_cnd),
		.i_din(i_din), .i_rxc_n(i_rxc_n), .i_txc_n(i_txc_n), .i_rxd(i_rxd),
		.i_ext_sync(i_ext_sync), .i_sync_match(i_sync_match), .i_sync_miss(i_sync_miss),
		.i_hunt(i_hunt), .i_tx_en(i_tx_en), .i_int_reset(i_int_reset),
		.o_mode_word(o_mode_word), .o_mode_loaded(o_mode_loaded), .o_mode_bad(o_mode_bad),
		.o_sync_mode(o_sync_mode), .o_rate(o_rate), .o_char_len(o_char_len),
		.o_parity_en(o_parity_en), .o_parity_even(o_parity_even), .o_stop_code(o_stop_code),
		.o_ext_sync_sel(o_ext_sync_sel), .o_single_sync(o_single_sync),
		.o_sync_locked(o_sync_locked), .o_cmd_wr(o_cmd_wr), .o_cmd_data(o_cmd_data),
		.o_tx_wr(o_tx_wr), .o_rx_sample(o_rx_sample), .o_rx_bit(o_rx_bit),
		.o_rx_frame_end(o_rx_frame_end), .o_rx_false_start(o_rx_false_start),
		.o_tx_shift(o_tx_shift), .o_tx_done(o_tx_done), .o_tx_busy(o_tx_busy)
	);
	umc_serial_peer i_umc_serial_peer (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_run(run), .i_rxd_lvl(rxd_lvl),
		.o_rxc_n(i_rxc_n), .o_txc_n(i_txc_n), .o_rxd(i_rxd)
	);
	// ----------------------------------------
	// clock, edge counters, pulse capture, hang limit
	// ----------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (i_rxc_n && !rxc_q)
			rise_n++;
		if (!i_txc_n && txc_q)
			fall_n++;
		if (o_rx_sample === 1'b1 && samp_at == 0)
			samp_at = rise_n;
		if (o_tx_shift === 1'b1) begin
			if (sh_n < 2)
				sh_at[sh_n] = fall_n;
			sh_n++;
		end
		if (o_cmd_wr === 1'b1)
			cmd_n++;
		if (o_tx_wr === 1'b1)
			twr_n++;
		if (o_tx_done === 1'b1 && done_at == 0)
			done_at = fall_n;
		if (o_rx_frame_end === 1'b1 && fe_at == 0)
			fe_at = rise_n;
		if (o_rx_false_start === 1'b1 && fs_at == 0)
			fs_at = rise_n;
		rxc_q = i_rxc_n;
		txc_q = i_txc_n;
		if (cyc > 40000) begin
			err_count++;
			stop_test();
		end
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask : tick
	task automatic reset_dut();
		i_rst = 1'b1;
		run = 1'b0;
		tick(6);
		i_rst = 1'b0;
		tick(1);
	endtask : reset_dut
	task automatic wr(input logic cnd, input logic [7:0] d, input int hold);
		{i_cs_n, i_wr_n, i_cnd, i_din} = {2'h0, cnd, d};
		tick(hold);
		{i_cs_n, i_wr_n} = 2'h3;
		tick(1);
	endtask : wr
	// k: 0 match, 1 miss, 2 hunt, 3 internal reset
	task automatic pul(input int k);
		{i_sync_match, i_sync_miss, i_hunt, i_int_reset} = 4'h8 >> k;
		tick(1);
		{i_sync_match, i_sync_miss, i_hunt, i_int_reset} = 4'h0;
		tick(2);
	endtask : pul
	task automatic stop_test();
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		{i_rst, i_cs_n, i_wr_n, i_cnd, i_din} = {3'h7, 1'b0, 8'h00};
		{i_ext_sync, i_sync_match, i_sync_miss, i_hunt, i_tx_en, i_int_reset} = 6'h00;
		{run, rxd_lvl, rxc_q, txc_q} = 4'h7;
		reset_dut();
		chk("reset_word", 8'h00, o_mode_word);
		chk("reset_flags", 8'h65, {o_mode_loaded, o_sync_mode, o_rx_bit, o_sync_locked, o_char_len});
		// every mode word value decoded
		for (int i = 0; i < 256; i++) begin
			m = 8'(i);
			s = (m[1:0] == 2'h0);
			pul(3);
			wr(1'b1, m, 1);
			tick(2);
			chk("mode_word", m, o_mode_word);
			e = {s, m[4], m[4] & m[5], ~s & (m[7:6] == 2'h0), 4'h5 + 4'(m[3:2])};
			g = {o_sync_mode, o_parity_en, o_parity_even, o_mode_bad, o_char_len};
			chk("format", e, g);
			e = {m[1:0], s ? 2'h0 : m[7:6], s & m[6], s & m[7], 2'h2};
			g = {o_rate, o_stop_code, o_ext_sync_sel, o_single_sync, o_mode_loaded, 1'b0};
			chk("options", e, g);
		end
		// later control write, held low several cycles, goes to the command path
		cmd_n = 0;
		wr(1'b1, 8'hA5, 4);
		tick(2);
		chk("cmd_count", 8'h01, 8'(cmd_n));
		chk("cmd_data", 8'hA5, o_cmd_data);
		chk("mode_kept", 8'hFF, o_mode_word);
		// receive sample point and transmit shift spacing for the x1, x16 and x64 rates
		for (int r = 1; r < 4; r++) begin
			reset_dut();
			wr(1'b1, {2'(r), 2'h0, 2'h3, 2'(r)}, 1);
			twr_n = 0;
			wr(1'b0, 8'h55, 1);
			rxd_lvl = 1'b0;
			rise_n = 0;
			samp_at = 0;
			fe_at = 0;
			sh_n = 0;
			run = 1'b1;
			tick(40);
			chk("shift_disabled", 8'h00, 8'(sh_n));
			chk("tx_wait_busy", 8'h01, {7'h00, o_tx_busy});
			chk("tx_wr_count", 8'h01, 8'(twr_n));
			fall_n = 0;
			done_at = 0;
			i_tx_en = 1'b1;
			for (n = 0; n < 4000 && (done_at == 0 || fe_at == 0); n++)
				tick(1);
			chk("rx_first", firsts[r], 8'(samp_at));
			chk("tx_first", 8'h01, 8'(sh_at[0]));
			chk("tx_next", 8'h01 + divs[r], 8'(sh_at[1]));
			chk("rx_frame_end", 16'(firsts[r] + 9 * divs[r]), 16'(fe_at));
			chk("tx_done_at", 16'(1 + 9 * divs[r] + stops[r]), 16'(done_at));
			chk("tx_idle", 8'h00, {7'h00, o_tx_busy});
			chk("rx_bit_low", 8'h00, {7'h00, o_rx_bit});
			i_tx_en = 1'b0;
			rxd_lvl = 1'b1;
		end
		// x16 start bit that is high again at bit centre is dropped
		reset_dut();
		wr(1'b1, 8'h4E, 1);
		rxd_lvl = 1'b0;
		rise_n = 0;
		fs_at = 0;
		run = 1'b1;
		tick(8);
		rxd_lvl = 1'b1;
		for (n = 0; n < 200 && fs_at == 0; n++)
			tick(1);
		chk("rx_false_start", 8'h09, 8'(fs_at));
		chk("rx_bit_high", 8'h01, {7'h00, o_rx_bit});
		// external sync: lock, then data from the next rising edge
		reset_dut();
		wr(1'b1, 8'h4C, 1);
		i_ext_sync = 1'b1;
		tick(3);
		chk("ext_lock", 8'h01, 8'(o_sync_locked));
		rise_n = 0;
		samp_at = 0;
		run = 1'b1;
		for (n = 0; n < 100 && samp_at == 0; n++)
			tick(1);
		chk("ext_first", 8'h01, 8'(samp_at));
		// internal detection, two characters, external indication ignored
		reset_dut();
		wr(1'b1, 8'h0C, 1);
		pul(0);
		chk("lock_one_of_two", 8'h00, 8'(o_sync_locked));
		pul(1);
		pul(0);
		chk("lock_after_miss", 8'h00, 8'(o_sync_locked));
		pul(0);
		chk("lock_two", 8'h01, 8'(o_sync_locked));
		pul(2);
		chk("lock_hunt", 8'h00, 8'(o_sync_locked));
		// internal detection, single character
		i_ext_sync = 1'b0;
		reset_dut();
		wr(1'b1, 8'h8C, 1);
		pul(0);
		chk("lock_single", 8'h01, 8'(o_sync_locked));
		stop_test();
	end
endmodule : umc_mode_config_tb
